// File: dv/dce_sync_serial_handshake_test.sv
// Purpose: Self-checking bench for the modem-side serial handshake
// Assumes: Short counts set through the top parameters
// Notes:   Terminal pins come from the behavioural terminal model
`timescale 1ns/1ps
`default_nettype none
module dce_sync_serial_handshake_test;
  import dce_sync_pkg::*;
  localparam int unsigned HB = 8;
  logic sys_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic full_duplex_i = 1'h0, off_hook_i = 1'h0, carrier_ok_i = 1'h0;
  logic rx_bit_i = 1'h1, rx_valid_i = 1'h0, link_ready_i = 1'h1, send = 1'h0;
  logic [7:0] tx_byte = 8'hA6;
  logic [7:0] rx_pat = 8'h5B;
  logic rts_n, txd, cts_n, rxd, tck_n, rck_n, cd_n, rx_ready, link_valid;
  logic [7:0] rx_byte;
  link_bit_t link_bit;
  mode_t mode;
  int mismatches = 0;
  int tests_run = 0;

  // Clock
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  dce_sync_serial_handshake #(.HALF_BIT_CYC_P(HB), .TURN_ON_CYC_P(4), .RXD_HOLD_CYC_P(40)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .rts_n_i(rts_n), .txd_i(txd),
    .full_duplex_i(full_duplex_i), .off_hook_i(off_hook_i), .carrier_ok_i(carrier_ok_i),
    .rx_bit_i(rx_bit_i), .rx_valid_i(rx_valid_i), .link_ready_i(link_ready_i), .cts_n_o(cts_n),
    .rxd_o(rxd), .tx_bit_clock_n_o(tck_n), .rx_bit_clock_n_o(rck_n), .carrier_detect_n_o(cd_n),
    .rx_ready_o(rx_ready), .link_bit_o(link_bit), .link_valid_o(link_valid), .mode_o(mode));

  dte_terminal_model term (
    .sys_clk_i(sys_clk_i), .send_i(send), .tx_byte_i(tx_byte), .cts_n_i(cts_n),
    .tx_bit_clock_n_i(tck_n), .rx_bit_clock_n_i(rck_n), .rxd_i(rxd), .rts_n_o(rts_n),
    .txd_o(txd), .rx_byte_o(rx_byte));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One sampled cycle of a bounded wait
  task automatic tick(inout int n);
    @(negedge sys_clk_i);
    n++;
    if (n > 1000) begin
      mismatches++;
      $display("ERROR wait expired");
      finish_test();
    end
  endtask

  task automatic wait_mode(input mode_t m);
    int n;
    n = 0;
    while (mode !== m) tick(n);
  endtask

  // Cycles one bit clock stays at a level
  task automatic span(input bit rx, input logic lvl, output int len);
    len = 0;
    while ((rx ? rck_n : tck_n) === lvl) tick(len);
  endtask

  task automatic grab(output link_bit_t b);
    int n;
    n = 0;
    tick(n);
    while (!(link_valid === 1'h1 && link_ready_i === 1'h1)) tick(n);
    b = link_bit;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (8) @(negedge sys_clk_i);
    check("reset pins", 8'hF8, {cts_n, rxd, tck_n, rck_n, cd_n, rx_ready, link_valid, 1'h0});
    check("reset mode", 8'h00, 8'(mode));
    @(posedge sys_clk_i) reset_i <= 1'h0;
  endtask

  task automatic t_send();
    link_bit_t b;
    logic [7:0] got;
    @(posedge sys_clk_i);
    carrier_ok_i <= 1'h1;
    link_ready_i <= 1'h0;
    send <= 1'h1;
    wait_mode(ST_TURN_ON);
    check("cts in turn-on", 8'h01, {7'h00, cts_n});
    wait_mode(ST_TRANSMIT);
    repeat (3) @(negedge sys_clk_i);
    check("cts in transmit", 8'h00, {7'h00, cts_n});
    repeat (6 * HB) @(negedge sys_clk_i);
    check("valid under stall", 8'h01, {7'h00, link_valid});
    @(posedge sys_clk_i) link_ready_i <= 1'h1;
    grab(b);
    check("first flag", 8'h01, {7'h00, b.first});
    for (int i = 0; i < 8 && b.data !== 1'h0; i++) grab(b);
    got[0] = b.data;
    for (int i = 1; i < 8; i++) begin
      grab(b);
      got[i] = b.data;
    end
    check("terminal byte", tx_byte, got);
  endtask

  task automatic t_tx_clock();
    int hi, lo;
    span(1'b0, 1'h1, hi);
    span(1'b0, 1'h0, lo);
    span(1'b0, 1'h1, hi);
    span(1'b0, 1'h0, lo);
    check("tx clock high", 8'(HB), 8'(hi));
    check("tx clock low", 8'(HB), 8'(lo));
  endtask

  task automatic t_drain();
    @(posedge sys_clk_i);
    rx_bit_i <= 1'h0;
    rx_valid_i <= 1'h1;
    link_ready_i <= 1'h0;
    repeat (4 * HB) @(posedge sys_clk_i);
    send <= 1'h0;
    repeat (20) begin
      @(negedge sys_clk_i);
      check("rxd mark hold", 8'h01, {7'h00, rxd});
    end
    check("mode drain", 8'(ST_DRAIN), 8'(mode));
    check("cts in drain", 8'h01, {7'h00, cts_n});
    @(posedge sys_clk_i) link_ready_i <= 1'h1;
    wait_mode(ST_RECEIVE);
    // Link still offers a space bit; the mark hold keeps it off the pin
    repeat (16) begin
      @(negedge sys_clk_i);
      check("rxd hold in receive", 8'h01, {7'h00, rxd});
    end
    @(posedge sys_clk_i) rx_valid_i <= 1'h0;
  endtask

  // Short request pulse: turn-on starts, is abandoned, transmit never reached
  task automatic t_abort();
    logic seen_on, seen_tx;
    seen_on = 1'h0;
    seen_tx = 1'h0;
    @(posedge sys_clk_i) send <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    send <= 1'h0;
    repeat (16) begin
      @(negedge sys_clk_i);
      seen_on |= (mode === ST_TURN_ON);
      seen_tx |= (mode === ST_TRANSMIT);
    end
    check("abort turn-on seen", 8'h02, {6'h00, seen_on, seen_tx});
    check("abort mode", 8'(ST_RECEIVE), 8'(mode));
    check("abort cts", 8'h01, {7'h00, cts_n});
  endtask

  task automatic t_rx();
    int n, hi, lo;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      rx_bit_i <= rx_pat[i];
      rx_valid_i <= 1'h1;
      n = 0;
      do tick(n); while (rx_ready !== 1'h1);
    end
    @(posedge sys_clk_i) rx_bit_i <= 1'h1;
    repeat (HB + 4) @(negedge sys_clk_i);
    check("received byte", rx_pat, rx_byte);
    span(1'b1, 1'h1, hi);
    span(1'b1, 1'h0, lo);
    span(1'b1, 1'h1, hi);
    check("rx clock low", 8'(HB), 8'(lo));
    check("rx clock high", 8'(HB), 8'(hi));
  endtask

  task automatic t_duplex();
    @(posedge sys_clk_i);
    full_duplex_i <= 1'h1;
    send <= 1'h1;
    repeat (8) @(negedge sys_clk_i);
    check("cts full duplex", 8'h00, {7'h00, cts_n});
    @(posedge sys_clk_i);
    off_hook_i <= 1'h1;
    carrier_ok_i <= 1'h0;
    repeat (4) @(negedge sys_clk_i);
    check("training cts cd", 8'h03, {6'h00, cts_n, cd_n});
    @(posedge sys_clk_i) carrier_ok_i <= 1'h1;
    repeat (4) @(negedge sys_clk_i);
    check("trained cts cd", 8'h00, {6'h00, cts_n, cd_n});
  endtask

  // Main sequence
  initial begin
    t_reset();
    t_send();
    t_tx_clock();
    t_drain();
    t_rx();
    t_abort();
    t_duplex();
    finish_test();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    mismatches++;
    $display("ERROR run limit expired");
    finish_test();
  end
endmodule // dce_sync_serial_handshake_test
`default_nettype wire

// File: dv/dte_terminal_model.sv
// Purpose: Behavioural terminal on the modem's serial pins
// Assumes: Bit clocks are seen through the system clock
// Notes:   Sends one byte LSB first, shifts in received bits
`timescale 1ns/1ps
`default_nettype none
module dte_terminal_model (
  input wire logic sys_clk_i,
  input wire logic send_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic cts_n_i,
  input wire logic tx_bit_clock_n_i,
  input wire logic rx_bit_clock_n_i,
  input wire logic rxd_i,
  output logic rts_n_o,
  output logic txd_o,
  output logic [7:0] rx_byte_o
);
  logic tck_q = 1'h1;
  logic rck_q = 1'h1;
  int idx = 0;
  initial begin
    rts_n_o = 1'h1;
    txd_o = 1'h1;
    rx_byte_o = 8'h00;
  end
  // Request follows the wish to send, clock edges found
  always @(posedge sys_clk_i) begin
    rts_n_o <= ~send_i;
    tck_q <= tx_bit_clock_n_i;
    rck_q <= rx_bit_clock_n_i;
  end
  // New data bit at each transmit clock fall, mark otherwise
  always @(posedge sys_clk_i) begin
    if (!send_i) begin
      idx <= 0;
      txd_o <= 1'h1;
    end else if (tck_q && !tx_bit_clock_n_i) begin
      if (!rts_n_o && !cts_n_i && idx < 8) begin
        txd_o <= tx_byte_i[idx];
        idx <= idx + 1;
      end else begin
        txd_o <= 1'h1;
      end
    end
  end
  // Received bit taken at receive clock rise
  always @(posedge sys_clk_i) begin
    if (!rck_q && rx_bit_clock_n_i) begin
      rx_byte_o <= {rxd_i, rx_byte_o[7:1]};
    end
  end
endmodule // dte_terminal_model
`default_nettype wire

// File: src/dce_sync_pkg.sv
// Purpose: Shared constants and types for the modem-side serial handshake
// Assumes: 125 MHz system clock, pins sampled through three flip-flops
// Notes:   Long counts reappear as top-level parameters so simulation can shorten them
package dce_sync_pkg;

  // System clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_HZ = 125_000_000;

  // Synchronous line rate and the half bit in clock cycles
  localparam int unsigned BIT_RATE_BPS = 1200;
  localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_BPS);

  // Delay from request-to-send low to transmit mode, least time, rounded up
  localparam int unsigned TURN_ON_US = 10;
  localparam int unsigned TURN_ON_CYC = (TURN_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Mark hold on the receive line after request-to-send rises, least time, rounded up
  localparam int unsigned RXD_HOLD_US = 2000;
  localparam int unsigned RXD_HOLD_CYC = (RXD_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pin synchroniser depth and the terminal data sample point after a clock rise
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned SAMPLE_AT = 3;

  // Reset levels of the interface pins (all idle high)
  localparam logic PIN_IDLE = 1'h1;

  // Line direction modes
  typedef enum logic [1:0] {
    ST_RECEIVE  = 2'b00,
    ST_TURN_ON  = 2'b01,
    ST_TRANSMIT = 2'b10,
    ST_DRAIN    = 2'b11
  } mode_t;

  // One terminal bit handed to the link
  typedef struct packed {
    logic data;
    logic first;
  } link_bit_t;

endpackage

// File: src/dce_sync_serial_handshake.sv
// Purpose: Modem-side request/clear-to-send handshake and synchronous bit clocks
// Assumes: Terminal changes data on our clock fall and samples on our clock rise
// Notes:   Pin levels are as on the wire, logic 0 is the active level
// Contract
// - Request-to-send held low keeps transmit mode; terminal bits are taken.
// - Request-to-send falling switches to transmit; clear-to-send goes low when ready.
// - Full duplex: request-to-send and clear-to-send both held low constantly; the code raises clear-to-send while training.
// - Request-to-send rising: finish data in progress, then return to receive.
// - Transmit bit clock runs at the bit rate with 50 percent duty; the code holds the fall while the buffer is full.
// - Transmit bit clock rising edge marks the centre of each terminal bit.
// - Receive bit clock runs at the bit rate with 50 percent duty.
// - Receive bit clock rising edge marks the centre of each received bit.
// - Receive line idles high and stays high briefly after request rises.
// - Synchronous: clear-to-send high on going off-hook until carrier detect low.
`timescale 1ns/1ps
`default_nettype none
module dce_sync_serial_handshake
  import dce_sync_pkg::*;
#(
  parameter int unsigned HALF_BIT_CYC_P = HALF_BIT_CYC,
  parameter int unsigned TURN_ON_CYC_P = TURN_ON_CYC,
  parameter int unsigned RXD_HOLD_CYC_P = RXD_HOLD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic rts_n_i,
  input wire logic txd_i,
  input wire logic full_duplex_i,
  input wire logic off_hook_i,
  input wire logic carrier_ok_i,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  input wire logic link_ready_i,
  output logic cts_n_o,
  output logic rxd_o,
  output logic tx_bit_clock_n_o,
  output logic rx_bit_clock_n_o,
  output logic carrier_detect_n_o,
  output logic rx_ready_o,
  output link_bit_t link_bit_o,
  output logic link_valid_o,
  output mode_t mode_o
);

  localparam int unsigned CW = $clog2(HALF_BIT_CYC_P + 1);
  localparam int unsigned TW = $clog2(TURN_ON_CYC_P + 1);
  localparam int unsigned HW = $clog2(RXD_HOLD_CYC_P + 1);
  localparam int unsigned NPIN = 2;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_q;
  logic rts_n_q;
  logic txd_q;
  logic rts_n_prev_q;
  logic rts_rise;
  logic training;
  logic [CW-1:0] tx_cnt_q;
  logic [CW-1:0] rx_cnt_q;
  logic tx_end;
  logic rx_end;
  logic tx_smp;
  logic tx_accept;
  logic push;
  logic buf_in_ready;
  logic first_pend_q;
  logic rx_allow;
  logic [TW-1:0] turn_cnt_q;
  logic [HW-1:0] hold_cnt_q;
  link_bit_t push_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, a change counts once stages two and three agree
  assign pin_raw = {txd_i, rts_n_i};
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] stg_q;
    logic stable_q;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
        stg_q <= {SYNC_STAGES{PIN_IDLE}};
        stable_q <= PIN_IDLE;
      end else begin
        stg_q <= {stg_q[SYNC_STAGES-2:0], pin_raw[g]};
        if (stg_q[SYNC_STAGES-1] == stg_q[SYNC_STAGES-2]) begin
          stable_q <= stg_q[SYNC_STAGES-1];
        end
      end
    end
    assign pin_q[g] = stable_q;
  end
  assign rts_n_q = pin_q[0];
  assign txd_q = pin_q[1];
  assign rts_rise = rts_n_q & ~rts_n_prev_q;

  // Request edge history and carrier detect pin
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rts_n_prev_q <= PIN_IDLE;
      carrier_detect_n_o <= PIN_IDLE;
    end else begin
      rts_n_prev_q <= rts_n_q;
      carrier_detect_n_o <= ~carrier_ok_i;
    end
  end
  assign training = off_hook_i & carrier_detect_n_o;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit bit clock, equal halves; fall held while the buffer is full
  assign tx_end = tx_cnt_q == CW'(HALF_BIT_CYC_P - 1);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_cnt_q <= '0;
      tx_bit_clock_n_o <= PIN_IDLE;
    end else if (!tx_end) begin
      tx_cnt_q <= tx_cnt_q + CW'(1);
    end else if (!tx_bit_clock_n_o || buf_in_ready) begin
      tx_cnt_q <= '0;
      tx_bit_clock_n_o <= ~tx_bit_clock_n_o;
    end
  end

  // Terminal bit taken just after the rise, once through the synchroniser
  assign tx_smp = tx_bit_clock_n_o && tx_cnt_q == CW'(SAMPLE_AT);
  assign tx_accept = full_duplex_i || mode_o == ST_TRANSMIT;
  assign push = tx_smp & tx_accept;
  assign push_bit = '{data: txd_q, first: first_pend_q};

  // First bit marker after entering transmit
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_pend_q <= 1'h1;
    end else if (!tx_accept) begin
      first_pend_q <= 1'h1;
    end else if (push) begin
      first_pend_q <= 1'h0;
    end
  end

  dce_two_entry_buf #(
    .WIDTH($bits(link_bit_t))
  ) u_tx_buf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(push_bit),
    .in_valid_i(push),
    .in_ready_o(buf_in_ready),
    .out_data_o(link_bit_o),
    .out_valid_o(link_valid_o),
    .out_ready_i(link_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive bit clock, free running with equal halves
  assign rx_end = rx_cnt_q == CW'(HALF_BIT_CYC_P - 1);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_cnt_q <= '0;
      rx_bit_clock_n_o <= PIN_IDLE;
    end else if (rx_end) begin
      rx_cnt_q <= '0;
      rx_bit_clock_n_o <= ~rx_bit_clock_n_o;
    end else begin
      rx_cnt_q <= rx_cnt_q + CW'(1);
    end
  end

  // Link bits accepted in the fall cycle, presented until the next fall
  assign rx_allow = (full_duplex_i || mode_o == ST_RECEIVE) && hold_cnt_q == '0 && !carrier_detect_n_o;
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_ready_o <= 1'h0;
      rxd_o <= PIN_IDLE;
    end else begin
      rx_ready_o <= rx_allow && rx_bit_clock_n_o && rx_cnt_q == CW'(HALF_BIT_CYC_P - 2);
      if (rx_end && rx_bit_clock_n_o) begin
        rxd_o <= (rx_ready_o && rx_valid_i) ? rx_bit_i : PIN_IDLE;
      end
    end
  end

  // Mark hold after request-to-send rises
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_cnt_q <= '0;
    end else if (rts_rise) begin
      hold_cnt_q <= HW'(RXD_HOLD_CYC_P);
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - HW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line direction; the terminal waits for clear-to-send before sending
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_o <= ST_RECEIVE;
      turn_cnt_q <= '0;
    end else begin
      case (mode_o)
        ST_RECEIVE: begin
          turn_cnt_q <= TW'(TURN_ON_CYC_P);
          if (!rts_n_q) begin
            mode_o <= ST_TURN_ON;
          end
        end
        ST_TURN_ON: begin
          if (turn_cnt_q != '0) begin
            turn_cnt_q <= turn_cnt_q - TW'(1);
          end
          if (rts_n_q) begin
            mode_o <= ST_RECEIVE;
          end else if (turn_cnt_q == '0 && !training) begin
            mode_o <= ST_TRANSMIT;
          end
        end
        ST_TRANSMIT: begin
          if (rts_n_q) begin
            mode_o <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!link_valid_o) begin
            mode_o <= ST_RECEIVE;
          end
        end
        default: begin
          mode_o <= ST_RECEIVE;
        end
      endcase
    end
  end

  // Clear-to-send: high while training, low in transmit or full duplex
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cts_n_o <= PIN_IDLE;
    end else begin
      cts_n_o <= training | ~tx_accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_req_low_rx;
    mode_o == ST_RECEIVE && !rts_n_q;
  endsequence
  sequence s_turn_done;
    mode_o == ST_TURN_ON && turn_cnt_q == '0 && !rts_n_q && !training;
  endsequence
  property p_accept;
    mode_o == ST_TRANSMIT && tx_smp |-> push && buf_in_ready;
  endproperty
  a_accept: assert property (p_accept) else $error("terminal bit not taken");
  property p_turn;
    s_req_low_rx |=> mode_o == ST_TURN_ON && turn_cnt_q == TW'(TURN_ON_CYC_P);
  endproperty
  a_turn: assert property (p_turn) else $error("turn on not started");
  property p_turn_done;
    s_turn_done |=> mode_o == ST_TRANSMIT ##1 cts_n_o == $past(training);
  endproperty
  a_turn_done: assert property (p_turn_done) else $error("no clear-to-send after turn on");
  property p_full;
    full_duplex_i && !training |=> !cts_n_o;
  endproperty
  a_full: assert property (p_full) else $error("clear-to-send high in full duplex");
  property p_drain;
    mode_o == ST_TRANSMIT && rts_n_q |=> mode_o == ST_DRAIN;
  endproperty
  a_drain: assert property (p_drain) else $error("no drain on request rise");
  property p_tx_half;
    $changed(tx_bit_clock_n_o) |-> $past(tx_cnt_q) == CW'(HALF_BIT_CYC_P - 1);
  endproperty
  a_tx_half: assert property (p_tx_half) else $error("tx clock half wrong");
  property p_tx_centre;
    push |-> tx_bit_clock_n_o && $past(tx_bit_clock_n_o, 3);
  endproperty
  a_tx_centre: assert property (p_tx_centre) else $error("terminal bit off centre");
  property p_rx_half;
    $changed(rx_bit_clock_n_o) |-> $past(rx_cnt_q) == CW'(HALF_BIT_CYC_P - 1);
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx clock half wrong");
  property p_rx_centre;
    $changed(rxd_o) |-> $fell(rx_bit_clock_n_o);
  endproperty
  a_rx_centre: assert property (p_rx_centre) else $error("rx data changed off fall");
  property p_hold;
    hold_cnt_q != '0 && $fell(rx_bit_clock_n_o) |-> rxd_o;
  endproperty
  a_hold: assert property (p_hold) else $error("rx data not mark in hold");
  property p_train;
    training |=> cts_n_o;
  endproperty
  a_train: assert property (p_train) else $error("clear-to-send low while training");

endmodule // dce_sync_serial_handshake
`default_nettype wire

// File: src/dce_two_entry_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, head entry always drives the output
// Notes:   Ready on the fill side drops only when both entries hold data
`timescale 1ns/1ps
`default_nettype none
module dce_two_entry_buf #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  logic [WIDTH-1:0] tail_q;
  logic tail_v_q;
  logic push;
  logic pop;

  assign in_ready_o = ~tail_v_q;
  assign push = in_valid_i & ~tail_v_q;
  assign pop = out_valid_o & out_ready_i;

  ////////////////////////////////////////////////////////////////////////////
  // Head entry, shifts up from the tail on a pop
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_data_o <= '0;
      out_valid_o <= 1'h0;
    end else if (pop || !out_valid_o) begin
      out_data_o <= tail_v_q ? tail_q : in_data_i;
      out_valid_o <= tail_v_q | push;
    end
  end

  // Tail entry, filled only while the head is held
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tail_q <= '0;
      tail_v_q <= 1'h0;
    end else if (pop) begin
      tail_q <= in_data_i;
      tail_v_q <= tail_v_q & push;
    end else if (push && out_valid_o) begin
      tail_q <= in_data_i;
      tail_v_q <= 1'h1;
    end
  end

endmodule // dce_two_entry_buf
`default_nettype wire
